// ### src/agl_pkg.sv
// Functional notes
// - error below threshold selects small gain, above selects large gain
// - second order loop filter with poles at one and at pole setting
// - gains and pole are eight bit fractions equal to code over 256
// - error threshold is four exponent bits plus eight mantissa bits
// - loop works on base two logs; gain is two to the filter output
// - gain applied to I and Q as coarse shift then fine multiply
// - initial gain in float format applies before loop runs
// - products are 19 bit scaled I and Q fed back for power
// - scaled outputs truncated to 4,5,6,7,8,10,12 or 16 bits
// - clipping mode zero uses only pre-clip path for level mode
// - clipping mode one locks loop onto a desired clipping level
// - clipping mode error is pre minus post truncation values
// - clipping mode subtracts desired clipping level from rms value
// - desired level is two exponent bits and six mantissa bits
// - sync from own oscillator start or one of four pins
// - software immediate sync bit makes a sync event
// - sync loads 16 bit holdoff counter, fires when count reaches one
// - fired sync dumps averager result then restarts accumulation
// - init on sync clears accumulator and reloads parameters
// - leaving sleep via oscillator start sync starts the process
// - first sync only bit ignores all syncs after the first
package agl_pkg;
    localparam int DATA_W = 16;
    localparam int SCALED_W = 19;
    localparam int LOG_W = 12; // 4.8 log2 units, 1 lsb = 0.024 dB
    localparam int FRAC_W = 8;
    localparam int HOLD_W = 16;
    localparam logic [HOLD_W-1:0] HOLD_FIRE = 16'h0001;
    localparam logic [LOG_W-1:0] GAIN_RESET = 12'h000;
    localparam logic [2:0] WL_RESET = 3'h7;

    typedef struct packed {
        logic clip_mode;
        logic chan_sync_sel;
        logic [1:0] pin_sel;
        logic sync_now;
        logic init_on_sync;
        logic first_sync_only;
        logic [2:0] word_len;
    } agl_ctrl_t;

    typedef struct packed {
        logic [7:0] small_gain;
        logic [7:0] large_gain;
        logic [7:0] pole;
        logic [LOG_W-1:0] threshold;
        logic [LOG_W-1:0] init_gain;
        logic [HOLD_W-1:0] holdoff;
        logic [7:0] desired_level;
    } agl_regs_t;

    typedef struct packed {
        logic signed [DATA_W-1:0] i;
        logic signed [DATA_W-1:0] q;
    } agl_iq_t;

    typedef struct packed {
        logic signed [SCALED_W-1:0] i;
        logic signed [SCALED_W-1:0] q;
    } agl_sc_t;
endpackage

// ### src/agl_gain_mult.sv
`timescale 1ns/1ps
`default_nettype none
module agl_gain_mult
    import agl_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic in_valid,
    input wire agl_iq_t in_iq,
    input wire logic [LOG_W-1:0] gain,
    output logic out_valid,
    output agl_sc_t out_sc
);
    typedef struct packed {
        logic valid;
        agl_sc_t sc;
    } agl_gm_state_t;

    agl_gm_state_t st, next_st;
    logic [8:0] mant;
    logic signed [41:0] pi, pq;

    // linear gain: 2^frac approx as 1+frac, times 2^int
    always_comb begin
        mant = {1'b1, gain[FRAC_W-1:0]};
        pi = (42'(in_iq.i) * $signed({1'b0, mant})) <<< gain[LOG_W-1:FRAC_W];
        pq = (42'(in_iq.q) * $signed({1'b0, mant})) <<< gain[LOG_W-1:FRAC_W];
        next_st.valid = in_valid;
        next_st.sc = st.sc;
        if (in_valid) begin
            next_st.sc.i = pi[FRAC_W+DATA_W+2:FRAC_W];
            next_st.sc.q = pq[FRAC_W+DATA_W+2:FRAC_W];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign out_valid = st.valid;
    assign out_sc = st.sc;
endmodule
`default_nettype wire

// ### src/agl_core.sv
`timescale 1ns/1ps
`default_nettype none
module agl_core
    import agl_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire agl_ctrl_t ctrl,
    input wire agl_regs_t regs,
    input wire logic osc_start_sync,
    input wire logic [3:0] sync_pins,
    input wire logic in_valid,
    input wire agl_iq_t in_iq,
    input wire logic [LOG_W-1:0] rms_log,
    output logic sync_fire,
    output logic cic_dump,
    output logic cic_init,
    output logic power_valid,
    output agl_sc_t power_iq,
    output logic out_valid,
    output agl_sc_t out_sc,
    output logic [LOG_W-1:0] signal_gain
);
    typedef struct packed {
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic prev_sync;
        logic seen_sync;
        logic [HOLD_W-1:0] count;
        logic counting;
        logic fire;
        logic init;
        logic [7:0] small_gain;
        logic [7:0] large_gain;
        logic [7:0] pole;
        logic signed [LOG_W+2:0] acc;
        logic signed [LOG_W+2:0] x1;
        logic [LOG_W-1:0] gain;
        logic ovalid;
        agl_sc_t osc;
        logic pvalid;
        agl_sc_t psc;
    } agl_state_t;

    agl_state_t st, next_st;
    logic [3:0] pin_d1, pin_d2;
    logic sync_src, sync_edge;
    logic signed [LOG_W+2:0] err, want, step, acc_n;
    logic [LOG_W-1:0] abs_err;
    logic [7:0] k;
    logic signed [LOG_W+12:0] kterm, pterm;
    logic [4:0] wl;
    logic gm_valid;
    agl_sc_t gm_sc, trunc;
    logic [LOG_W-1:0] gain_d;

    agl_gain_mult u_mult (
        .mclk(mclk),
        .reset(reset),
        .in_valid(in_valid),
        .in_iq(in_iq),
        .gain(st.gain),
        .out_valid(gm_valid),
        .out_sc(gm_sc)
    );

    // two stage synchroniser for the sync pins
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_d1 <= '0;
            pin_d2 <= '0;
        end else begin
            pin_d1 <= sync_pins;
            pin_d2 <= pin_d1;
        end
    end

    // word length decode to kept bits
    always_comb begin
        unique case (ctrl.word_len)
            3'h0: wl = 5'h04;
            3'h1: wl = 5'h05;
            3'h2: wl = 5'h06;
            3'h3: wl = 5'h07;
            3'h4: wl = 5'h08;
            3'h5: wl = 5'h0A;
            3'h6: wl = 5'h0C;
            3'h7: wl = 5'h10;
        endcase
    end

    always_comb begin
        trunc.i = (gm_sc.i >>> (5'(SCALED_W) - wl)) <<< (5'(SCALED_W) - wl);
        trunc.q = (gm_sc.q >>> (5'(SCALED_W) - wl)) <<< (5'(SCALED_W) - wl);
    end

    always_comb begin
        next_st = st;
        // source select, channel oscillator or pin
        sync_src = ctrl.chan_sync_sel ? osc_start_sync : pin_d2[ctrl.pin_sel];
        sync_edge = (sync_src & ~st.prev_sync) | ctrl.sync_now;
        next_st.prev_sync = sync_src;
        next_st.fire = 1'b0;
        next_st.init = 1'b0;
        if (sync_edge && !(ctrl.first_sync_only && st.seen_sync)) begin
            next_st.seen_sync = 1'b1;
            next_st.count = regs.holdoff;
            next_st.counting = 1'b1;
        end else if (st.counting) begin
            if (st.count <= HOLD_FIRE) begin
                next_st.counting = 1'b0;
                next_st.fire = 1'b1;
                next_st.init = ctrl.init_on_sync;
            end else begin
                next_st.count = st.count - 16'h0001;
            end
        end
        if (st.init) begin
            next_st.small_gain = regs.small_gain;
            next_st.large_gain = regs.large_gain;
            next_st.pole = regs.pole;
            next_st.gain = regs.init_gain;
            next_st.acc = '0;
            next_st.x1 = $signed({3'h0, regs.init_gain});
        end
        // desired level: exp*512 + mant*4 (0.094 dB = 4 lsb)
        want = $signed({1'b0, regs.desired_level[7:6], 1'b0,
            regs.desired_level[5:0], 2'h0, 3'h0}) >>> 3;
        err = $signed({3'h0, rms_log}) - want;
        abs_err = err[LOG_W+2] ? LOG_W'(-err) : LOG_W'(err);
        k = (abs_err > regs.threshold) ? st.large_gain : st.small_gain;
        // acc = acc*pole - K*err ; x = x1 + acc
        kterm = (LOG_W+13)'(err) * $signed({1'b0, k});
        pterm = (LOG_W+13)'(st.acc) * $signed({1'b0, st.pole});
        step = (LOG_W+3)'(kterm >>> FRAC_W);
        acc_n = (LOG_W+3)'(pterm >>> FRAC_W) - step;
        // loop updates only at the dump
        if (st.fire && !st.init) begin
            next_st.acc = acc_n;
            next_st.x1 = st.x1 + acc_n;
            if (st.x1 + acc_n < 0) begin
                next_st.gain = '0;
            end else if (st.x1 + acc_n > $signed({3'h0, {LOG_W{1'b1}}})) begin
                next_st.gain = '1;
            end else begin
                next_st.gain = LOG_W'(st.x1 + acc_n);
            end
        end
        next_st.ovalid = gm_valid;
        next_st.pvalid = gm_valid;
        if (gm_valid) begin
            next_st.osc = trunc;
            // clip mode feeds truncation error, else pre-clip path
            if (ctrl.clip_mode) begin
                next_st.psc.i = gm_sc.i - trunc.i;
                next_st.psc.q = gm_sc.q - trunc.q;
            end else begin
                next_st.psc = gm_sc;
            end
        end
    end

    // state register; reset loads GAIN_RESET, initial gain taken at an init on sync
    always_ff @(posedge mclk) begin
        if (reset) begin
            st <= '0;
            st.gain <= GAIN_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign sync_fire = st.fire;
    assign cic_dump = st.fire;
    assign cic_init = st.init;
    assign power_valid = st.pvalid;
    assign power_iq = st.psc;
    assign out_valid = st.ovalid;
    assign out_sc = st.osc;
    assign signal_gain = st.gain;

    // helper for assertions
    always_ff @(posedge mclk) begin
        gain_d <= st.gain;
    end

    a_holdoff_fire: assert property (@(posedge mclk) disable iff (reset)
        (sync_edge && !ctrl.first_sync_only && regs.holdoff == 16'h0001 &&
         !st.counting) |=> ##1 st.fire)
        else $error("holdoff of one did not fire");
    a_gain_steady: assert property (@(posedge mclk) disable iff (reset)
        (!st.fire && !st.init) |=> (st.gain == gain_d))
        else $error("gain moved between updates");
    a_first_only: assert property (@(posedge mclk) disable iff (reset)
        (ctrl.first_sync_only && st.seen_sync && !st.counting && sync_edge)
        |=> !st.counting)
        else $error("later sync not ignored");
    a_init_reload: assert property (@(posedge mclk) disable iff (reset)
        st.init |=> (st.gain == $past(regs.init_gain) && st.acc == 0))
        else $error("init did not reload gain");
    a_clip_err: assert property (@(posedge mclk) disable iff (reset)
        (gm_valid && ctrl.clip_mode) |=>
        (st.psc.i == $past(gm_sc.i) - $past(trunc.i)))
        else $error("clip error term wrong");
    a_level_path: assert property (@(posedge mclk) disable iff (reset)
        (gm_valid && !ctrl.clip_mode) |=> (st.psc == $past(gm_sc)))
        else $error("level mode path wrong");
    a_init_follows: assert property (@(posedge mclk) disable iff (reset)
        st.init |-> st.fire)
        else $error("init without dump");
    a_trunc_low: assert property (@(posedge mclk) disable iff (reset)
        (st.ovalid && $past(ctrl.word_len) == 3'h0) |->
        (st.osc.i[14:0] == 15'h0000))
        else $error("truncation left low bits");
endmodule
`default_nettype wire

// ### tb/agl_partner.sv
`timescale 1ns/1ps
`default_nettype none
module agl_partner
    import agl_pkg::*;
(
    input wire logic mclk,
    input wire logic [3:0] pin_req,
    input wire logic osc_req,
    output logic in_valid,
    output agl_iq_t in_iq,
    output logic [LOG_W-1:0] rms_log,
    output logic [3:0] sync_pins,
    output logic osc_start_sync
);
    integer seed = 32'hE37C02BC;
    // quiet lines at time zero
    initial begin
        in_valid = 1'b0;
        in_iq = '0;
        rms_log = '0;
        sync_pins = 4'h0;
        osc_start_sync = 1'b0;
    end
    // random samples and level, sync lines follow requests
    // pin and oscillator starts
    always @(posedge mclk) begin
        in_valid <= 1'($random(seed));
        in_iq <= $random(seed);
        rms_log <= 12'($random(seed));
        sync_pins <= pin_req;
        osc_start_sync <= osc_req;
    end
endmodule
`default_nettype wire

// ### tb/agl_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module agl_core_tb_top;
    import agl_pkg::*;
    localparam logic [HOLD_W-1:0] H = 16'h0005;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    agl_ctrl_t ctrl = '0;
    agl_regs_t regs = '0;
    logic [3:0] pin_req = 4'h0;
    logic osc_req = 1'b0;
    logic in_valid, osc_start_sync, sync_fire, cic_dump, cic_init;
    logic power_valid, out_valid, v1, v2, run;
    agl_iq_t in_iq;
    agl_sc_t power_iq, out_sc;
    logic [LOG_W-1:0] rms_log, signal_gain, g;
    logic [3:0] sync_pins;
    agl_iq_t d1, d2;
    logic [LOG_W-1:0] g1, g2;
    logic [2:0] w2;
    logic m2;
    logic signed [SCALED_W-1:0] ei, eq;
    integer seed = 32'hE37C02BC;
    int n_errors = 0;
    int compares = 0;
    agl_partner agl_partner_inst (.mclk(mclk), .pin_req(pin_req),
        .osc_req(osc_req), .in_valid(in_valid), .in_iq(in_iq),
        .rms_log(rms_log), .sync_pins(sync_pins),
        .osc_start_sync(osc_start_sync));
    agl_core agl_core_inst (.mclk(mclk), .reset(reset), .ctrl(ctrl),
        .regs(regs), .osc_start_sync(osc_start_sync),
        .sync_pins(sync_pins), .in_valid(in_valid), .in_iq(in_iq),
        .rms_log(rms_log), .sync_fire(sync_fire), .cic_dump(cic_dump),
        .cic_init(cic_init), .power_valid(power_valid),
        .power_iq(power_iq), .out_valid(out_valid), .out_sc(out_sc),
        .signal_gain(signal_gain));
    // clock at 5 ns
    always #2.5 mclk = ~mclk;
    // coarse shift and fine multiply of one sample by a 4.8 gain
    function automatic logic signed [SCALED_W-1:0] scale(
        logic signed [DATA_W-1:0] x, logic [LOG_W-1:0] gn);
        logic signed [41:0] p;
        p = (42'(x) * 42'(10'h100 + 10'(gn[7:0]))) <<< gn[11:8];
        return p[26:8];
    endfunction
    // keep only the top bits of the chosen word length
    function automatic logic signed [SCALED_W-1:0] cut(
        logic signed [SCALED_W-1:0] x, logic [2:0] w);
        int keep;
        keep = (w < 3'h5) ? 4 + int'(w) : ((w == 3'h7) ? 16 : 2 * int'(w));
        return (x >>> (SCALED_W - keep)) <<< (SCALED_W - keep);
    endfunction
    // sample, gain and mode history for the two-cycle data latency
    always @(posedge mclk) begin
        v1 <= in_valid && !reset;
        v2 <= v1 && !reset;
        d1 <= in_iq;
        d2 <= d1;
        g1 <= signal_gain;
        g2 <= g1;
        w2 <= ctrl.word_len;
        m2 <= ctrl.clip_mode;
    end
    always @(negedge mclk) begin
        if (run) begin
            `CHK("out_valid", v2, out_valid)
            `CHK("power_valid", v2, power_valid)
            if (v2) begin
                ei = scale(d2.i, g2);
                eq = scale(d2.q, g2);
                `CHK("out_i", cut(ei, w2), out_sc.i)
                `CHK("out_q", cut(eq, w2), out_sc.q)
                if (m2) begin
                    `CHK("clip_i", ei - cut(ei, w2), power_iq.i)
                end else begin
                    `CHK("power_q", eq, power_iq.q)
                end
            end
        end
    end
    task automatic print_verdict();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // wait for a fire, expect latency lat when nonzero
    task automatic wait_fire(string nm, logic want, int lat, logic ini);
        int n;
        logic hit;
        n = 0;
        hit = 1'b0;
        while (n < H + 10 && !hit) begin
            #1 hit = sync_fire;
            if (!hit) begin
                @(posedge mclk);
                n++;
            end
        end
        `CHK(nm, want, hit)
        if (hit && lat > 0) `CHK("fire_lat", lat, n)
        if (hit) `CHK("cic_init", ini, cic_init)
        if (hit) `CHK("cic_dump", 1'b1, cic_dump)
        repeat (H + 4) @(posedge mclk);
        $display("test %s done", nm);
    endtask
    task automatic soft_sync(string nm, logic ini, logic want);
        @(posedge mclk);
        ctrl.init_on_sync <= ini;
        ctrl.sync_now <= 1'b1;
        @(posedge mclk);
        ctrl.sync_now <= 1'b0;
        wait_fire(nm, want, 32'(regs.holdoff), ini);
    endtask
    task automatic pulse(string nm, logic [3:0] pins, logic osc, logic want);
        pin_req <= pins;
        osc_req <= osc;
        repeat (3) @(posedge mclk);
        pin_req <= 4'h0;
        osc_req <= 1'b0;
        wait_fire(nm, want, 0, ctrl.init_on_sync);
    endtask
    initial begin
        #(5 * 20000);
        n_errors++;
        print_verdict();
    end
    initial begin
        run = 1'b0;
        regs <= {8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
            12'h789, 12'h789, H, 8'hA5};
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1 `CHK("rst_gain", 12'h000, signal_gain)
        run = 1'b1;
        soft_sync("init", 1'b1, 1'b1);
        #1 `CHK("gain_init", 12'h789, signal_gain)
        g = signal_gain;
        repeat (20) @(posedge mclk);
        #1 `CHK("gain_hold", g, signal_gain)
        ctrl.clip_mode <= 1'b1;
        soft_sync("noinit", 1'b0, 1'b1);
        // each selected pin fires, the next pin ignored
        for (int p = 0; p < 4; p++) begin
            ctrl.pin_sel <= 2'(p);
            ctrl.word_len <= 3'(p * 2);
            pulse("pin", 4'(1 << p), 1'b0, 1'b1);
            pulse("pin_other", 4'(1 << ((p + 1) % 4)), 1'b0, 1'b0);
        end
        ctrl.chan_sync_sel <= 1'b1;
        pulse("osc", 4'hF, 1'b1, 1'b1);
        // hold-off of one fires on the next edge
        regs.holdoff <= 16'h0001;
        soft_sync("hold1", 1'b0, 1'b1);
        // only first sync after reset counts
        run = 1'b0;
        reset <= 1'b1;
        ctrl.first_sync_only <= 1'b1;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        run = 1'b1;
        soft_sync("first", 1'b1, 1'b1);
        soft_sync("later", 1'b1, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
